// ===== hw/timer8.sv
`timescale 1ns/1ps
`default_nettype none
`include "timer8_defines.svh"

// How it works
// - Force strobe in non-PWM mode applies output action to its pin at once
// - Forced compare sets no flag and never clears the counter
// - Force strobe bits are pulses and read back as zero
// - Reserved bits of control B, mask and flags read as zero
// - Select 0 stops, 1 undivided, 2..5 divide by 8, 64, 256, 1024
// - Select 6 counts falling pin edges, 7 counts rising pin edges
// - Pin edges count regardless of the pin's direction
// - Count register is read and written directly by software
// - Count write blocks compare matches on the next timer tick
// - Both compare registers continuously compared, drive flags and pins
// - Mask bit2 compare B, bit1 compare A, bit0 overflow; gated by global
// - Match with compare A sets flag bit 1
// - Match with compare B sets flag bit 2
// - Overflow flag bit 0 set where the mode places overflow
// - Flags clear on vector execution or writing one; zero leaves them
// - Control B bit 3 is the top bit of the wave mode
// - Overflow at MAX, BOTTOM in phase modes, TOP in fast with A top
// - Non-PWM actions: off, toggle, clear, set; forced compare does likewise
module timer8
    import timer8_pkg::*;
#(
    parameter int PRESCALE_BITS = 10
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Register port
    input wire reg_req_t req_i,
    output logic [7:0] rdata_o,
    // Interrupt side
    input wire logic global_irq_enable_i,
    input wire vec_ack_t vec_ack_i,
    output logic irq_a_o,
    output logic irq_b_o,
    output logic irq_ovf_o,
    // Pins
    input wire logic ext_count_clock_pin_i,
    output logic wave_out_a_o,
    output logic wave_out_b_o,
    output logic wave_en_a_o,
    output logic wave_en_b_o
);

    if (PRESCALE_BITS < 10) begin : g_bad_prescale
        $error("Prescaler too short for /1024");
    end

    logic [7:0] control_a;
    logic [3:0] control_b;
    logic [7:0] counter_value;
    logic [7:0] compare_a_value;
    logic [7:0] compare_b_value;
    logic [2:0] irq_mask;
    logic [2:0] irq_flags;
    logic [PRESCALE_BITS-1:0] prescale;
    logic [2:0] pin_sync;
    logic count_down;
    logic block_match;
    logic tick;
    logic [7:0] top;
    logic is_pwm;
    logic [7:0] next_count;
    logic next_down;
    logic match_a;
    logic match_b;
    logic ovf_evt;

    wave_mode_t wave_mode;
    clock_select_t clock_select;
    logic wr_b;
    logic wr_cnt;
    logic wr_flags;
    logic [1:0] output_a_action;
    logic [1:0] output_b_action;

    assign clock_select = clock_select_t'(control_b[2:0]);
    assign wave_mode = wave_mode_t'({control_b[`CTLB_WAVE_BIT2],
                                     control_a[1:0]});
    assign output_a_action = control_a[`CTLA_ACT_A_HI:`CTLA_ACT_A_LO];
    assign output_b_action = control_a[`CTLA_ACT_B_HI:`CTLA_ACT_B_LO];
    assign wr_b = req_i.wr && req_i.addr == `OFS_CONTROL_B;
    assign wr_cnt = req_i.wr && req_i.addr == `OFS_COUNT;
    assign wr_flags = req_i.wr && req_i.addr == `OFS_IRQ_FLAGS;
    assign is_pwm = wave_mode != WM_NORMAL && wave_mode != WM_CTC;

    // Registers
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            control_a <= `RESET_BYTE;
            control_b <= 4'h0;
            compare_a_value <= `RESET_BYTE;
            compare_b_value <= `RESET_BYTE;
            irq_mask <= 3'h0;
        end else if (req_i.wr) begin
            case (req_i.addr)
                `OFS_CONTROL_A: control_a <= req_i.wdata & `CTLA_RW_MASK;
                `OFS_CONTROL_B: control_b <= req_i.wdata[3:0];
                `OFS_COMPARE_A: compare_a_value <= req_i.wdata;
                `OFS_COMPARE_B: compare_b_value <= req_i.wdata;
                `OFS_IRQ_MASK: irq_mask <= req_i.wdata[2:0];
                default: ;
            endcase
        end
    end

    // Prescaler and pin sync
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            prescale <= '0;
            pin_sync <= 3'h0;
        end else begin
            prescale <= prescale + 1'b1;
            pin_sync <= {pin_sync[1:0], ext_count_clock_pin_i};
        end
    end

    function automatic logic div_tick(input logic [10:0] ratio,
                                      input logic [PRESCALE_BITS-1:0] p);
        logic [PRESCALE_BITS-1:0] m;
        m = PRESCALE_BITS'(ratio - 11'h001);
        return (p & m) == m;
    endfunction

    // Tick select
    always_comb begin
        case (clock_select)
            CS_STOP: tick = 1'b0;
            CS_DIV1: tick = 1'b1;
            CS_DIV8: tick = div_tick(`DIV_8, prescale);
            CS_DIV64: tick = div_tick(`DIV_64, prescale);
            CS_DIV256: tick = div_tick(`DIV_256, prescale);
            CS_DIV1024: tick = div_tick(`DIV_1024, prescale);
            CS_EXT_FALL: tick = pin_sync[2] && !pin_sync[1];
            CS_EXT_RISE: tick = !pin_sync[2] && pin_sync[1];
            default: tick = 1'b0;
        endcase
    end

    // Count sequence
    always_comb begin
        top = `COUNT_MAX;
        if (wave_mode == WM_CTC || wave_mode == WM_PHASE_A ||
            wave_mode == WM_FAST_A) begin
            top = compare_a_value;
        end
        next_count = counter_value + 8'h01;
        next_down = count_down;
        ovf_evt = 1'b0;
        case (wave_mode)
            WM_PHASE_FF, WM_PHASE_A: begin
                if (count_down) begin
                    if (counter_value == `COUNT_BOTTOM) begin
                        next_count = 8'h01;
                        next_down = 1'b0;
                        ovf_evt = 1'b1;
                    end else begin
                        next_count = counter_value - 8'h01;
                    end
                end else if (counter_value >= top) begin
                    next_count = counter_value - 8'h01;
                    next_down = 1'b1;
                end
            end
            WM_CTC: begin
                if (counter_value == top) next_count = `COUNT_BOTTOM;
                ovf_evt = counter_value == `COUNT_MAX;
            end
            WM_FAST_A: begin
                if (counter_value == top) begin
                    next_count = `COUNT_BOTTOM;
                    ovf_evt = 1'b1;
                end
            end
            default: ovf_evt = counter_value == `COUNT_MAX;
        endcase
    end

    assign match_a = tick && !block_match &&
                     counter_value == compare_a_value;
    assign match_b = tick && !block_match &&
                     counter_value == compare_b_value;

    // Counter
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            counter_value <= `RESET_BYTE;
            count_down <= 1'b0;
            block_match <= 1'b0;
        end else if (wr_cnt) begin
            counter_value <= req_i.wdata;
            block_match <= 1'b1;
        end else if (tick) begin
            counter_value <= next_count;
            count_down <= next_down;
            block_match <= 1'b0;
        end
    end

    // Flags: set wins over clear
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_flags <= 3'h0;
        end else begin
            irq_flags[`IRQ_CMP_A] <= match_a || (irq_flags[`IRQ_CMP_A] &&
                !vec_ack_i.vec_a &&
                !(wr_flags && req_i.wdata[`IRQ_CMP_A]));
            irq_flags[`IRQ_CMP_B] <= match_b || (irq_flags[`IRQ_CMP_B] &&
                !vec_ack_i.vec_b &&
                !(wr_flags && req_i.wdata[`IRQ_CMP_B]));
            irq_flags[`IRQ_OVF] <= (tick && ovf_evt) ||
                (irq_flags[`IRQ_OVF] && !vec_ack_i.vec_ovf &&
                !(wr_flags && req_i.wdata[`IRQ_OVF]));
        end
    end

    assign irq_a_o = global_irq_enable_i && irq_mask[`IRQ_CMP_A] &&
                     irq_flags[`IRQ_CMP_A];
    assign irq_b_o = global_irq_enable_i && irq_mask[`IRQ_CMP_B] &&
                     irq_flags[`IRQ_CMP_B];
    assign irq_ovf_o = global_irq_enable_i && irq_mask[`IRQ_OVF] &&
                       irq_flags[`IRQ_OVF];

    function automatic logic apply_action(input logic [1:0] act,
                                          input logic cur);
        case (act)
            2'h1: return !cur;
            2'h2: return 1'b0;
            2'h3: return 1'b1;
            default: return cur;
        endcase
    endfunction

    logic force_a;
    logic force_b;
    assign force_a = wr_b && req_i.wdata[`CTLB_FORCE_A] && !is_pwm;
    assign force_b = wr_b && req_i.wdata[`CTLB_FORCE_B] && !is_pwm;

    // Waveform outputs (PWM shaping kept minimal: match actions)
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wave_out_a_o <= 1'b0;
            wave_out_b_o <= 1'b0;
        end else begin
            if (match_a || force_a)
                wave_out_a_o <= apply_action(output_a_action, wave_out_a_o);
            if (match_b || force_b)
                wave_out_b_o <= apply_action(output_b_action, wave_out_b_o);
        end
    end

    assign wave_en_a_o = output_a_action != 2'h0;
    assign wave_en_b_o = output_b_action != 2'h0;

    // Read port
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o <= `RESET_BYTE;
        end else if (req_i.rd) begin
            case (req_i.addr)
                `OFS_CONTROL_A: rdata_o <= control_a;
                `OFS_CONTROL_B: rdata_o <= {4'h0, control_b};
                `OFS_COUNT: rdata_o <= counter_value;
                `OFS_COMPARE_A: rdata_o <= compare_a_value;
                `OFS_COMPARE_B: rdata_o <= compare_b_value;
                `OFS_IRQ_MASK: rdata_o <= {5'h00, irq_mask};
                `OFS_IRQ_FLAGS: rdata_o <= {5'h00, irq_flags};
                default: rdata_o <= `RESET_BYTE;
            endcase
        end else begin
            rdata_o <= `RESET_BYTE;
        end
    end

    chk_force_no_flag: assert property (@(posedge clk_i) disable iff (rst_i)
        force_a && !match_a && !vec_ack_i.vec_a && !irq_flags[`IRQ_CMP_A]
        |=> !irq_flags[`IRQ_CMP_A])
        else $error("Forced compare set flag");
    chk_force_toggle: assert property (@(posedge clk_i) disable iff (rst_i)
        force_a && output_a_action == 2'h1 && !match_a
        |=> wave_out_a_o != $past(wave_out_a_o))
        else $error("Forced toggle missing");
    chk_count_write_block: assert property (@(posedge clk_i)
        disable iff (rst_i)
        wr_cnt |=> !match_a && !match_b)
        else $error("Match after count write");
    chk_match_sets_a: assert property (@(posedge clk_i) disable iff (rst_i)
        match_a |=> irq_flags[`IRQ_CMP_A])
        else $error("Compare A flag not set");
    chk_match_sets_b: assert property (@(posedge clk_i) disable iff (rst_i)
        match_b |=> irq_flags[`IRQ_CMP_B])
        else $error("Compare B flag not set");
    chk_flag_w1c: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_flags && req_i.wdata[`IRQ_OVF] && !(tick && ovf_evt)
        |=> !irq_flags[`IRQ_OVF])
        else $error("Overflow flag not cleared");
    chk_stop_holds: assert property (@(posedge clk_i) disable iff (rst_i)
        clock_select == CS_STOP && !wr_cnt |=> $stable(counter_value))
        else $error("Stopped counter moved");
    chk_ctlb_read: assert property (@(posedge clk_i) disable iff (rst_i)
        req_i.rd && req_i.addr == `OFS_CONTROL_B
        |=> rdata_o[7:4] == 4'h0)
        else $error("Control B upper bits nonzero");
    chk_irq_gate: assert property (@(posedge clk_i) disable iff (rst_i)
        irq_a_o |-> irq_flags[`IRQ_CMP_A] && irq_mask[`IRQ_CMP_A])
        else $error("Interrupt without flag and enable");
    chk_ovf_sets_flag: assert property (@(posedge clk_i)
        disable iff (rst_i) tick && ovf_evt |=> irq_flags[`IRQ_OVF])
        else $error("Overflow flag not set");
    chk_vec_clears_a: assert property (@(posedge clk_i)
        disable iff (rst_i) vec_ack_i.vec_a && !match_a
        |=> !irq_flags[`IRQ_CMP_A]) else $error("Vector left flag A set");
    chk_vec_clears_ovf: assert property (@(posedge clk_i)
        disable iff (rst_i) vec_ack_i.vec_ovf && !(tick && ovf_evt)
        |=> !irq_flags[`IRQ_OVF]) else $error("Vector left overflow set");
    chk_pwm_force_off: assert property (@(posedge clk_i)
        disable iff (rst_i) is_pwm && !match_a
        |=> wave_out_a_o == $past(wave_out_a_o)) else $error("PWM pin moved");
    chk_ext_edge_count: assert property (@(posedge clk_i)
        disable iff (rst_i) clock_select == CS_EXT_RISE && !wr_cnt &&
        wave_mode == WM_NORMAL && !pin_sync[2] && pin_sync[1]
        |=> counter_value == $past(counter_value) + 8'h01)
        else $error("Rising pin edge not counted");
    chk_mask_read: assert property (@(posedge clk_i)
        disable iff (rst_i) req_i.rd && req_i.addr == `OFS_IRQ_MASK
        |=> rdata_o[7:3] == 5'h00) else $error("Mask reserved bits set");
    chk_flags_read: assert property (@(posedge clk_i)
        disable iff (rst_i) req_i.rd && req_i.addr == `OFS_IRQ_FLAGS
        |=> rdata_o[7:3] == 5'h00) else $error("Flag reserved bits set");
    chk_force_no_clear: assert property (@(posedge clk_i)
        disable iff (rst_i) force_a && !tick && !wr_cnt
        |=> $stable(counter_value)) else $error("Forced compare moved count");

    cov_ovf: cover property (@(posedge clk_i) tick && ovf_evt);
    cov_force: cover property (@(posedge clk_i) force_b);
    cov_ext: cover property (@(posedge clk_i)
        clock_select == CS_EXT_RISE && tick);
    cov_ctc_wrap: cover property (@(posedge clk_i)
        tick && wave_mode == WM_CTC && counter_value == top);
    cov_phase_bottom: cover property (@(posedge clk_i)
        tick && ovf_evt && wave_mode == WM_PHASE_A);

endmodule
`default_nettype wire

// ===== hw/timer8_defines.svh
`ifndef TIMER8_DEFINES_SVH
`define TIMER8_DEFINES_SVH

// Register offsets (byte addresses on the plain register port)
`define OFS_CONTROL_A 4'h0
`define OFS_CONTROL_B 4'h1
`define OFS_COUNT 4'h2
`define OFS_COMPARE_A 4'h3
`define OFS_COMPARE_B 4'h4
`define OFS_IRQ_MASK 4'h5
`define OFS_IRQ_FLAGS 4'h6

// Control B fields
`define CTLB_FORCE_A 7
`define CTLB_FORCE_B 6
`define CTLB_WAVE_BIT2 3
`define CTLB_RW_MASK 8'h0F

// Control A fields
`define CTLA_ACT_A_HI 7
`define CTLA_ACT_A_LO 6
`define CTLA_ACT_B_HI 5
`define CTLA_ACT_B_LO 4
`define CTLA_RW_MASK 8'hF3

// Irq bits
`define IRQ_OVF 0
`define IRQ_CMP_A 1
`define IRQ_CMP_B 2
`define IRQ_RW_MASK 8'h07

`define RESET_BYTE 8'h00
`define COUNT_MAX 8'hFF
`define COUNT_BOTTOM 8'h00

// Prescaler ratios
`define DIV_8 11'h008
`define DIV_64 11'h040
`define DIV_256 11'h100
`define DIV_1024 11'h400

`endif

// ===== hw/timer8_pkg.sv
package timer8_pkg;

    typedef enum logic [2:0] {
        CS_STOP = 3'h0,
        CS_DIV1 = 3'h1,
        CS_DIV8 = 3'h2,
        CS_DIV64 = 3'h3,
        CS_DIV256 = 3'h4,
        CS_DIV1024 = 3'h5,
        CS_EXT_FALL = 3'h6,
        CS_EXT_RISE = 3'h7
    } clock_select_t;

    typedef enum logic [2:0] {
        WM_NORMAL = 3'h0,
        WM_PHASE_FF = 3'h1,
        WM_CTC = 3'h2,
        WM_FAST_FF = 3'h3,
        WM_RSVD4 = 3'h4,
        WM_PHASE_A = 3'h5,
        WM_RSVD6 = 3'h6,
        WM_FAST_A = 3'h7
    } wave_mode_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    typedef struct packed {
        logic vec_a;
        logic vec_b;
        logic vec_ovf;
    } vec_ack_t;

endpackage

// ===== verif/pin_pulse_model.sv
`timescale 1ns/1ps
`default_nettype none
// Far side of the count pin: bursts of clean pulses
module pin_pulse_model (
    // Clock
    input wire logic clk_i,
    // Burst command
    input wire logic start_i,
    input wire logic [7:0] pulses_i,
    input wire logic [7:0] width_i,
    // Pin side
    output logic pin_o,
    output logic busy_o
);
    initial begin
        pin_o = 1'b0;
        busy_o = 1'b0;
        forever begin
            @(posedge clk_i);
            if (start_i) begin
                busy_o <= 1'b1;
                // High and low phases of width_i clocks each
                repeat (pulses_i) begin
                    repeat (width_i) @(posedge clk_i);
                    pin_o <= 1'b1;
                    repeat (width_i) @(posedge clk_i);
                    pin_o <= 1'b0;
                end
                @(posedge clk_i);
                busy_o <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ===== verif/tb_timer8_control_and_flags.sv
`timescale 1ns/1ps
`default_nettype none
`include "timer8_defines.svh"
module tb_timer8_control_and_flags
    import timer8_pkg::*;
;
    logic clk_i, rst_i, glob, pin, start, busy, wa, wb, ea, eb, ia, ib, iov;
    logic oa, ob;
    reg_req_t req;
    vec_ack_t vec;
    logic [7:0] rdata, v, pw;
    int failures, compares, seed, i;

    timer8 #(.PRESCALE_BITS(10)) dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .req_i(req), .rdata_o(rdata),
        .global_irq_enable_i(glob), .vec_ack_i(vec),
        .irq_a_o(ia), .irq_b_o(ib), .irq_ovf_o(iov),
        .ext_count_clock_pin_i(pin), .wave_out_a_o(wa), .wave_out_b_o(wb),
        .wave_en_a_o(ea), .wave_en_b_o(eb)
    );

    pin_pulse_model pin_u (
        .clk_i(clk_i), .start_i(start), .pulses_i(8'h05), .width_i(pw),
        .pin_o(pin), .busy_o(busy)
    );

    function automatic int ratio(input int cs);
        case (cs)
            2: return 8;
            3: return 64;
            4: return 256;
            5: return 1024;
            default: return 1;
        endcase
    endfunction

    function automatic logic act_out(input logic [1:0] a, input logic cur);
        case (a)
            2'h1: return ~cur;
            2'h2: return 1'b0;
            2'h3: return 1'b1;
            default: return cur;
        endcase
    endfunction

    task automatic wr(input logic [3:0] a, input logic [7:0] x);
        @(posedge clk_i);
        req.wr <= 1'b1;
        req.addr <= a;
        req.wdata <= x;
        @(posedge clk_i);
        req.wr <= 1'b0;
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        req.rd <= 1'b1;
        req.addr <= a;
        @(posedge clk_i);
        req.rd <= 1'b0;
        #1;
        chk8(rdata, exp);
    endtask

    task automatic run_mode(input logic [2:0] m, input logic [7:0] ec,
                            input logic [7:0] ef);
        wr(`OFS_CONTROL_A, {6'h00, m[1:0]});
        wr(`OFS_IRQ_FLAGS, 8'h07);
        wr(`OFS_COUNT, 8'h00);
        wr(`OFS_CONTROL_B, {4'h0, m[2], 3'h1});
        repeat (7) @(posedge clk_i);
        wr(`OFS_CONTROL_B, {4'h0, m[2], 3'h0});
        chk_rd(`OFS_COUNT, ec);
        chk_rd(`OFS_IRQ_FLAGS, ef);
    endtask

    task automatic finish_test();
        $display("Counts: failures=%0d compares=%0d", failures, compares);
        if (failures == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    initial begin
        repeat (60000) @(posedge clk_i);
        failures++;
        finish_test();
    end

    initial begin
        seed = 66811;
        failures = 0;
        compares = 0;
        rst_i = 1'b1;
        req = '0;
        vec = '0;
        glob = 1'b0;
        start = 1'b0;
        pw = 8'h02;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        // Reset values and unmapped places
        for (i = 0; i < 16; i++) chk_rd(i[3:0], 8'h00);
        // Random write and read back, counter stopped
        for (i = 0; i < 8; i++) begin
            v = 8'($random(seed));
            wr(`OFS_CONTROL_B, v & 8'hF8);
            chk_rd(`OFS_CONTROL_B, v & 8'h08);
            wr(`OFS_IRQ_MASK, v);
            chk_rd(`OFS_IRQ_MASK, v & 8'h07);
            wr(`OFS_COMPARE_A, v);
            chk_rd(`OFS_COMPARE_A, v);
            wr(`OFS_COMPARE_B, ~v);
            chk_rd(`OFS_COMPARE_B, ~v);
            wr(`OFS_COUNT, v);
            chk_rd(`OFS_COUNT, v);
        end
        chk_rd(`OFS_IRQ_FLAGS, 8'h00);
        // Prescaler: eight ticks in a window of eight periods
        for (i = 1; i < 6; i++) begin
            wr(`OFS_COUNT, 8'h00);
            wr(`OFS_CONTROL_B, 8'(i));
            repeat (ratio(i) * 8 - 2) @(posedge clk_i);
            wr(`OFS_CONTROL_B, 8'h00);
            chk_rd(`OFS_COUNT, 8'h08);
        end
        repeat (20) @(posedge clk_i);
        chk_rd(`OFS_COUNT, 8'h08);
        // External pin, falling then rising edges
        for (i = 6; i < 8; i++) begin
            wr(`OFS_COUNT, 8'h00);
            wr(`OFS_CONTROL_B, 8'(i));
            pw <= (i == 6) ? 8'h02 : 8'h07;
            start <= 1'b1;
            @(posedge clk_i);
            start <= 1'b0;
            repeat (2) @(posedge clk_i);
            repeat (200) begin
                @(posedge clk_i);
                if (busy === 1'b0) break;
            end
            repeat (6) @(posedge clk_i);
            wr(`OFS_CONTROL_B, 8'h00);
            chk_rd(`OFS_COUNT, 8'h05);
        end
        // Matches: A toggles, B sets, all irqs enabled
        wr(`OFS_CONTROL_A, 8'h70);
        wr(`OFS_COMPARE_A, 8'h03);
        wr(`OFS_COMPARE_B, 8'h05);
        wr(`OFS_COUNT, 8'h00);
        wr(`OFS_IRQ_MASK, 8'h07);
        glob <= 1'b1;
        wr(`OFS_CONTROL_B, 8'h01);
        repeat (20) @(posedge clk_i);
        wr(`OFS_CONTROL_B, 8'h00);
        chk_rd(`OFS_IRQ_FLAGS, 8'h06);
        chk8({1'b0, ea, eb, wa, wb, ia, ib, iov}, 8'h7E);
        oa = 1'b1;
        ob = 1'b1;
        glob <= 1'b0;
        @(posedge clk_i);
        #1;
        chk8({5'h00, ia, ib, iov}, 8'h00);
        wr(`OFS_IRQ_FLAGS, 8'h00);
        chk_rd(`OFS_IRQ_FLAGS, 8'h06);
        wr(`OFS_IRQ_FLAGS, 8'h02);
        chk_rd(`OFS_IRQ_FLAGS, 8'h04);
        @(posedge clk_i);
        vec.vec_b <= 1'b1;
        @(posedge clk_i);
        vec.vec_b <= 1'b0;
        chk_rd(`OFS_IRQ_FLAGS, 8'h00);
        // Count written while running hides the next match
        wr(`OFS_COMPARE_A, 8'h40);
        wr(`OFS_CONTROL_B, 8'h01);
        wr(`OFS_COUNT, 8'h40);
        repeat (10) @(posedge clk_i);
        wr(`OFS_CONTROL_B, 8'h00);
        chk_rd(`OFS_IRQ_FLAGS, 8'h00);
        chk8({7'h00, wa}, {7'h00, oa});
        // Overflow past the maximum
        wr(`OFS_COMPARE_B, 8'h80);
        wr(`OFS_COUNT, 8'hFC);
        wr(`OFS_CONTROL_B, 8'h01);
        repeat (8) @(posedge clk_i);
        wr(`OFS_CONTROL_B, 8'h00);
        chk_rd(`OFS_IRQ_FLAGS, 8'h01);
        glob <= 1'b1;
        #1;
        chk8({5'h00, ia, ib, iov}, 8'h01);
        // Forced compares with set, clear and toggle actions
        for (i = 3; i > 0; i--) begin
            wr(`OFS_CONTROL_A, {i[1:0], i[1:0], 4'h0});
            wr(`OFS_CONTROL_B, 8'hC0);
            @(posedge clk_i);
            #1;
            oa = act_out(i[1:0], oa);
            ob = act_out(i[1:0], ob);
            chk8({4'h0, ea, eb, wa, wb}, {4'h0, 2'b11, oa, ob});
        end
        chk_rd(`OFS_IRQ_FLAGS, 8'h01);
        chk_rd(`OFS_COUNT, 8'h06);
        wr(`OFS_CONTROL_A, 8'h00);
        @(posedge clk_i);
        #1;
        chk8({6'h00, ea, eb}, 8'h00);
        // Force in fast mode is ignored
        wr(`OFS_CONTROL_A, 8'h73);
        wr(`OFS_CONTROL_B, 8'hC0);
        @(posedge clk_i);
        #1;
        chk8({6'h00, wa, wb}, {6'h00, oa, ob});
        wr(`OFS_CONTROL_B, 8'h00);
        // Modes with compare A as top: clear on match, phase, fast
        wr(`OFS_COMPARE_A, 8'h04);
        run_mode(3'h2, 8'h04, 8'h02);
        run_mode(3'h5, 8'h01, 8'h03);
        run_mode(3'h7, 8'h04, 8'h03);
        @(posedge clk_i);
        vec.vec_a <= 1'b1;
        vec.vec_ovf <= 1'b1;
        @(posedge clk_i);
        vec <= '0;
        chk_rd(`OFS_IRQ_FLAGS, 8'h00);
        finish_test();
    end
endmodule
`default_nettype wire
